// File: logic/mbx_exec_top.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] Jump loads its 11-bit operand into program counter bits 10:0.
// [RULE2] Jump fills program counter bits 12:11 from latch bits 4:3.
// [RULE3] Jump takes two cycles and changes no status flag.
// [RULE4] OR-literal ORs accumulator with 8-bit literal into accumulator, updates zero.
// [RULE5] Increment adds one to the addressed file register, updates zero.
// [RULE6] OR-with-file ORs accumulator with the file register, updates zero.
// [RULE7] Increment and OR-with-file: destination 0 to accumulator, 1 to file.
// [RULE8] Copy moves the file register to accumulator or back to itself.
// [RULE9] Copy updates zero for either destination, acting as a zero test.
// [RULE10] Store writes accumulator to the file register, flags unchanged.
// [RULE11] Zero is set on a zero 8-bit result; copy and store take one cycle.
module mbx_exec_top (
  input wire logic sys_clk, // 50 MHz core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Write protection, unused
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Read protection, unused
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [12:0] progCounter, // Program counter
  output logic busy // Instruction in progress
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_JUMP2
  } mbx_state_t;

  // Core state
  mbx_state_t state_r, state_nxt;
  logic [13:0] instr_r, instr_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic zero_r, zero_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [4:0] latch_r, latch_nxt;
  logic [6:0] fAddr_r, fAddr_nxt;

  // Bus state
  logic awHeld_r, awHeld_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // Helper nets
  logic commit;
  logic wrMapped;
  logic rdMapped;
  logic [31:0] wMask;
  logic [31:0] wOld;
  logic [31:0] wMerged;
  logic [31:0] rdValue;
  logic [7:0] aluResult;
  logic aluWrAcc;
  logic aluWrFile;
  logic aluUpdZero;
  logic aluZero;
  mbx_pkg::mbx_op_t curOp;

  mbx_file_if fileBus();

  mbx_file_ram u_file_ram (
    .sys_clk(sys_clk),
    .fileBus(fileBus.array)
  );

  mbx_alu u_alu (
    .instr(instr_r),
    .acc(acc_r),
    .fileData(fileBus.rDataA),
    .result(aluResult),
    .wrAcc(aluWrAcc),
    .wrFile(aluWrFile),
    .updZero(aluUpdZero),
    .resultZero(aluZero)
  );

  assign curOp = mbx_pkg::mbx_op_t'(instr_r[mbx_pkg::OP_MSB:mbx_pkg::OP_LSB]);

  // Port A follows the executing instruction, port B the software window
  assign fileBus.rAddrA = instr_r[mbx_pkg::FILE_MSB:0];
  assign fileBus.rAddrB = fAddr_r;

  // A register write waits for an idle core so it never races an execution
  assign commit = awHeld_r && wHeld_r && !bvalid_r && (state_r == ST_IDLE);

  // Address decode shared by both directions
  function automatic logic isMapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      mbx_pkg::ADDR_INSTR, mbx_pkg::ADDR_ACC, mbx_pkg::ADDR_STATUS,
      mbx_pkg::ADDR_PC, mbx_pkg::ADDR_LATCH, mbx_pkg::ADDR_FADDR,
      mbx_pkg::ADDR_FDATA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : isMapped

  assign wrMapped = isMapped(awAddr_r);
  assign rdMapped = isMapped(s_axi_araddr);

  // Byte-lane merge keeps unstrobed bytes at their current value, or zero for the instruction word
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wMask[i*8 +: 8] = {8{wStrb_r[i]}};
    end
  end

  // Present value of the register being written; zero for the instruction word
  always_comb begin
    case (awAddr_r)
      mbx_pkg::ADDR_ACC: wOld = {24'h000000, acc_r};
      mbx_pkg::ADDR_STATUS: wOld = {31'h00000000, zero_r};
      mbx_pkg::ADDR_LATCH: wOld = {27'h0000000, latch_r};
      mbx_pkg::ADDR_FADDR: wOld = {25'h0000000, fAddr_r};
      mbx_pkg::ADDR_FDATA: wOld = {24'h000000, fileBus.rDataB};
      default: wOld = 32'h00000000;
    endcase
  end

  assign wMerged = (wOld & ~wMask) | (wData_r & wMask);

  // Read multiplexer; reserved bits read as zero
  always_comb begin
    case (s_axi_araddr)
      mbx_pkg::ADDR_INSTR: rdValue = {18'h00000, instr_r};
      mbx_pkg::ADDR_ACC: rdValue = {24'h000000, acc_r};
      mbx_pkg::ADDR_STATUS: rdValue = {30'h00000000, busy, zero_r};
      mbx_pkg::ADDR_PC: rdValue = {19'h00000, pc_r};
      mbx_pkg::ADDR_LATCH: rdValue = {27'h0000000, latch_r};
      mbx_pkg::ADDR_FADDR: rdValue = {25'h0000000, fAddr_r};
      mbx_pkg::ADDR_FDATA: rdValue = {24'h000000, fileBus.rDataB};
      default: rdValue = 32'h00000000;
    endcase
  end

  // Core next state: register writes in idle, one operation per issue
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    pc_nxt = pc_r;
    latch_nxt = latch_r;
    fAddr_nxt = fAddr_r;
    fileBus.we = 1'b0;
    fileBus.wAddr = fAddr_r;
    fileBus.wData = wMerged[7:0];
    case (state_r)
      ST_IDLE: begin
        if (commit) begin
          case (awAddr_r)
            mbx_pkg::ADDR_INSTR: begin
              // Any strobed byte issues the merged word as an instruction
              if (|wStrb_r) begin
                instr_nxt = wMerged[mbx_pkg::INSTR_W-1:0];
                state_nxt = ST_EXEC;
              end
            end
            mbx_pkg::ADDR_ACC: acc_nxt = wMerged[7:0];
            mbx_pkg::ADDR_STATUS: zero_nxt = wMerged[mbx_pkg::ST_ZERO];
            mbx_pkg::ADDR_LATCH: latch_nxt = wMerged[mbx_pkg::LATCH_W-1:0];
            mbx_pkg::ADDR_FADDR: fAddr_nxt = wMerged[mbx_pkg::FILE_MSB:0];
            mbx_pkg::ADDR_FDATA: fileBus.we = 1'b1;
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_EXEC: begin
        // Destination steering and flag update come from the ALU
        fileBus.wAddr = instr_r[mbx_pkg::FILE_MSB:0];
        fileBus.wData = aluResult;
        fileBus.we = aluWrFile; // [RULE7] [RULE8] [RULE10]
        if (aluWrAcc) begin
          acc_nxt = aluResult; // [RULE4] [RULE7]
        end
        if (aluUpdZero) begin
          zero_nxt = aluZero; // [RULE9] [RULE11]
        end
        if (curOp == mbx_pkg::MBX_OP_JUMP) begin
          pc_nxt = {latch_r[mbx_pkg::LATCH_HI:mbx_pkg::LATCH_LO],
                    instr_r[mbx_pkg::TARGET_MSB:0]}; // [RULE1] [RULE2]
          state_nxt = ST_JUMP2; // [RULE3]
        end else begin
          pc_nxt = 13'(pc_r + 13'h0001);
          state_nxt = ST_IDLE; // [RULE11]
        end
      end
      ST_JUMP2: begin
        // Second jump cycle: refetch slot, flags left alone
        state_nxt = ST_IDLE; // [RULE3]
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Core registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      instr_r <= mbx_pkg::INSTR_RST;
      acc_r <= mbx_pkg::ACC_RST;
      zero_r <= 1'b0;
      pc_r <= mbx_pkg::PC_RST;
      latch_r <= mbx_pkg::LATCH_RST;
      fAddr_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
      pc_r <= pc_nxt;
      latch_r <= latch_nxt;
      fAddr_r <= fAddr_nxt;
    end
  end

  // Address and data are taken separately, in either order
  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;

  // Bus next state
  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (commit) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wrMapped ? mbx_pkg::RESP_OKAY : mbx_pkg::RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Reads are served at once, even mid-instruction
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rdValue;
      rresp_nxt = rdMapped ? mbx_pkg::RESP_OKAY : mbx_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= mbx_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= mbx_pkg::RESP_OKAY;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Outputs
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign progCounter = pc_r;
  assign busy = (state_r != ST_IDLE);

endmodule : mbx_exec_top
`default_nettype wire

// File: pkg/mbx_pkg.sv
package mbx_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_LATCH = 8'h10;
  localparam logic [7:0] ADDR_FADDR = 8'h14;
  localparam logic [7:0] ADDR_FDATA = 8'h18;

  // Status register fields
  localparam int ST_ZERO = 0;
  localparam int ST_BUSY = 1;

  // Instruction word fields
  localparam int INSTR_W = 14;
  localparam int OP_MSB = 13;
  localparam int OP_LSB = 11;
  localparam int DEST_BIT = 7;
  localparam int FILE_MSB = 6;
  localparam int LIT_MSB = 7;
  localparam int TARGET_MSB = 10;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // Widths of the core state
  localparam int PC_W = 13;
  localparam int LATCH_W = 5;
  localparam int FILE_DEPTH = 128;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  // Instruction cycles
  localparam int JUMP_CYCLES = 2;
  localparam int PLAIN_CYCLES = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes in instruction bits 13:11
  typedef enum logic [2:0] {
    MBX_OP_NOP = 3'h0,
    MBX_OP_JUMP = 3'h1,
    MBX_OP_ORLIT = 3'h2,
    MBX_OP_INC = 3'h3,
    MBX_OP_ORFILE = 3'h4,
    MBX_OP_COPY = 3'h5,
    MBX_OP_STORE = 3'h6
  } mbx_op_t;

endpackage : mbx_pkg

// File: pkg/mbx_file_if.sv
`timescale 1ns/10ps
`default_nettype none
// File register array access: one write port, two read ports
interface mbx_file_if;
  logic we;
  logic [6:0] wAddr;
  logic [7:0] wData;
  logic [6:0] rAddrA;
  logic [7:0] rDataA;
  logic [6:0] rAddrB;
  logic [7:0] rDataB;
  modport array (input we, wAddr, wData, rAddrA, rAddrB, output rDataA, rDataB);
  modport user (output we, wAddr, wData, rAddrA, rAddrB, input rDataA, rDataB);
endinterface : mbx_file_if
`default_nettype wire

// File: logic/mbx_file_ram.sv
`timescale 1ns/10ps
`default_nettype none
module mbx_file_ram (
  input wire logic sys_clk, // Core clock
  mbx_file_if.array fileBus // Array ports
);

  logic [7:0] mem [mbx_pkg::FILE_DEPTH];

  // Storage only; contents are undefined after reset like real file RAM
  always_ff @(posedge sys_clk) begin
    if (fileBus.we) begin
      mem[fileBus.wAddr] <= fileBus.wData;
    end
  end

  // Asynchronous reads so an operation finishes in its own cycle
  assign fileBus.rDataA = mem[fileBus.rAddrA];
  assign fileBus.rDataB = mem[fileBus.rAddrB];

endmodule : mbx_file_ram
`default_nettype wire

// File: logic/mbx_alu.sv
`timescale 1ns/10ps
`default_nettype none
module mbx_alu (
  input wire logic [13:0] instr, // Instruction word
  input wire logic [7:0] acc, // Accumulator
  input wire logic [7:0] fileData, // Addressed file register
  output logic [7:0] result, // Operation result
  output logic wrAcc, // Result goes to accumulator
  output logic wrFile, // Result goes to file register
  output logic updZero, // Zero flag takes resultZero
  output logic resultZero // Result is zero
);

  mbx_pkg::mbx_op_t op;
  logic dest;
  logic [7:0] lit;

  assign op = mbx_pkg::mbx_op_t'(instr[mbx_pkg::OP_MSB:mbx_pkg::OP_LSB]);
  assign dest = instr[mbx_pkg::DEST_BIT];
  assign lit = instr[mbx_pkg::LIT_MSB:0];

  // Result and its steering; jump and unused codes write nothing
  always_comb begin
    result = 8'h00;
    wrAcc = 1'b0;
    wrFile = 1'b0;
    updZero = 1'b0;
    case (op)
      mbx_pkg::MBX_OP_ORLIT: begin
        result = acc | lit; // [RULE4]
        wrAcc = 1'b1;
        updZero = 1'b1;
      end
      mbx_pkg::MBX_OP_INC: begin
        result = 8'(fileData + 8'h01); // [RULE5]
        wrAcc = ~dest; // [RULE7]
        wrFile = dest;
        updZero = 1'b1;
      end
      mbx_pkg::MBX_OP_ORFILE: begin
        result = acc | fileData; // [RULE6]
        wrAcc = ~dest; // [RULE7]
        wrFile = dest;
        updZero = 1'b1;
      end
      mbx_pkg::MBX_OP_COPY: begin
        result = fileData; // [RULE8]
        wrAcc = ~dest;
        wrFile = dest;
        updZero = 1'b1; // [RULE9]
      end
      mbx_pkg::MBX_OP_STORE: begin
        result = acc; // [RULE10]
        wrFile = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // Zero test on the full 8-bit result
  assign resultZero = (result == 8'h00); // [RULE11]

endmodule : mbx_alu
`default_nettype wire

// File: verif/mbx_exec_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Watches bus handshakes and instruction timing at the block boundary
module mbx_exec_checker (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [12:0] progCounter, // Program counter
  input wire logic busy // Instruction in progress
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Program counter only moves as an instruction leaves its execute cycle
  property p_pcOnExec; $changed(progCounter) |-> $past(busy); endproperty
  a_pcOnExec: assert property (p_pcOnExec) else $error("pc moved while idle");
  property p_jumpLen; busy [*2] |=> !busy; endproperty
  a_jumpLen: assert property (p_jumpLen) else $error("busy beyond two cycles");
  property p_plainStep; $rose(busy) ##1 !busy |-> progCounter == $past(progCounter) + 13'h1;
  endproperty
  a_plainStep: assert property (p_plainStep) else $error("one cycle op bad pc");
  // Instruction issue and write completion are tied together
  property p_busyWithResp; $rose(busy) |-> s_axi_bvalid; endproperty
  a_busyWithResp: assert property (p_busyWithResp) else $error("issue without response");
  property p_noCommitBusy; $rose(s_axi_bvalid) |-> !$past(busy); endproperty
  a_noCommitBusy: assert property (p_noCommitBusy) else $error("write done while busy");
  property p_wrLat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !busy |-> ##2 s_axi_bvalid;
  endproperty
  a_wrLat: assert property (p_wrLat) else $error("write response late");
  property p_wrBlocked; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wrBlocked: assert property (p_wrBlocked) else $error("write taken with response open");
  // Answers stand until the master takes them
  property p_respHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_respHold: assert property (p_respHold) else $error("write response dropped");
  property p_readLat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_readLat: assert property (p_readLat) else $error("read data late");
  property p_readHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_readHold: assert property (p_readHold) else $error("read data dropped");
endmodule : mbx_exec_checker
bind mbx_exec_top mbx_exec_checker i_mbx_exec_checker (.*);
`default_nettype wire

// File: verif/mbx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Software side of the register bus; can hold off its response ready
module mbx_host_model (
  input wire logic sys_clk, // Core clock
  input wire logic stallMode, // Delay taking answers
  output logic [7:0] s_axi_awaddr, // Write address
  output logic [2:0] s_axi_awprot, // Always zero
  output logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  output logic [31:0] s_axi_wdata, // Write data
  output logic [3:0] s_axi_wstrb, // All lanes except in the testbench strobe test
  output logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Response valid
  output logic s_axi_bready, // Response ready
  output logic [7:0] s_axi_araddr, // Read address
  output logic [2:0] s_axi_arprot, // Always zero
  output logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  output logic s_axi_rready // Read data ready
);
  // Quiet bus at time zero
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Released payload is inverted so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !stallMode;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    if (stallMode) begin
      repeat (2) @(posedge sys_clk);
      s_axi_bready <= 1'b1;
      @(posedge sys_clk);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read with the same hold rules as the write
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !stallMode;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    if (stallMode) begin
      repeat (2) @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      @(posedge sys_clk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : mbx_host_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk, rst_n, stallMode, busy;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, accM;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [12:0] progCounter;
  logic [12:0] pcM = 13'h0;
  logic [7:0] fileM [128];
  logic [4:0] latchM;
  logic zM = 1'b0;
  integer seed = 32'h59f1;
  int badCount = 0;
  int comparisons = 0;
  int cycles = 0;
  // Wrap to zero, zero tests, both jump extremes, top file address
  logic [13:0] corners [9] = '{14'h1885, 14'h2885, 14'h2805, 14'h1000, 14'h0fff, 14'h0800,
    14'h20ff, 14'h187f, 14'h307f};
  mbx_exec_top i_mbx_exec_top (.*);
  mbx_host_model i_mbx_host_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // A full run needs well under a third of this ceiling
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      badCount++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      badCount++;
    end
  endtask : chk
  task rdChk(input logic [7:0] a, input logic [31:0] e);
    i_mbx_host_model.rd(a, rdat, resp);
    chk(rdat, e);
  endtask : rdChk
  // Every mapped write must be answered with an OKAY response
  task wrOk(input logic [7:0] a, input logic [31:0] d);
    i_mbx_host_model.wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, mbx_pkg::RESP_OKAY});
  endtask : wrOk
  // Result that an arithmetic or move instruction should produce
  function automatic logic [7:0] resultOf(logic [13:0] ins, logic [7:0] fv);
    case (ins[13:11])
      3'h2: return accM | ins[7:0]; // OR literal
      3'h3: return fv + 8'h01; // Increment
      3'h4: return accM | fv; // OR file
      default: return fv; // Copy
    endcase
  endfunction : resultOf
  // Issue one instruction, update the model, then read back accumulator, flags, program counter and the file register
  task issue(input logic [13:0] ins);
    logic [2:0] op;
    logic [6:0] fa;
    logic [7:0] res;
    logic fileOp;
    op = ins[13:11];
    fa = ins[6:0];
    fileOp = op inside {3'h3, 3'h4, 3'h5};
    res = resultOf(ins, fileM[fa]);
    wrOk(mbx_pkg::ADDR_INSTR, {18'h0, ins});
    if (op == 3'h1) pcM = {latchM[4:3], ins[10:0]}; // Jump target
    else pcM = pcM + 13'h1;
    if (op == 3'h6) fileM[fa] = accM; // Store
    else if (op == 3'h2 || (fileOp && !ins[7])) accM = res; // Destination
    else if (fileOp) fileM[fa] = res;
    if (op == 3'h2 || fileOp) zM = (res == 8'h00); // Zero flag
    rdChk(mbx_pkg::ADDR_ACC, {24'h0, accM}); // Accumulator
    rdChk(mbx_pkg::ADDR_STATUS, {31'h0, zM}); // Flags
    rdChk(mbx_pkg::ADDR_PC, {19'h0, pcM}); // Program counter
    // Pin is looked at only after the reads, long after its update edge
    chk({19'h0, progCounter}, {19'h0, pcM}); // Program counter pins
    wrOk(mbx_pkg::ADDR_FADDR, {25'h0, fa});
    rdChk(mbx_pkg::ADDR_FDATA, {24'h0, fileM[fa]}); // File register
  endtask : issue
  // Main sequence
  initial begin
    rst_n = 1'b0;
    stallMode = 1'b0;
    accM = 8'h00;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdChk(mbx_pkg::ADDR_ACC, 32'h0);
    rdChk(mbx_pkg::ADDR_STATUS, 32'h0);
    rdChk(mbx_pkg::ADDR_PC, 32'h0);
    $display("test reset end");
    i_mbx_host_model.wr(8'h1c, 32'hffffffff, resp);
    chk({30'h0, resp}, {30'h0, mbx_pkg::RESP_SLVERR});
    rdChk(8'h1c, 32'h0);
    chk({30'h0, resp}, {30'h0, mbx_pkg::RESP_SLVERR});
    $display("test unmapped end");
    for (int i = 0; i < 128; i++) begin
      fileM[i] = (i == 5) ? 8'hff : 8'($random(seed));
      wrOk(mbx_pkg::ADDR_FADDR, i);
      wrOk(mbx_pkg::ADDR_FDATA, {24'h0, fileM[i]});
    end
    for (int i = 0; i < 80; i++) begin
      stallMode <= 1'($random(seed));
      latchM = 5'($random(seed));
      zM = 1'($random(seed));
      wrOk(mbx_pkg::ADDR_LATCH, {27'h0, latchM});
      wrOk(mbx_pkg::ADDR_STATUS, {31'h0, zM});
      if (i >= 9) begin
        accM = 8'($random(seed));
        wrOk(mbx_pkg::ADDR_ACC, {24'h0, accM});
      end
      issue(i < 9 ? corners[i] : 14'($random(seed)));
    end
    $display("test instructions end");
    // An empty strobe issues nothing, and unstrobed lanes keep their value
    i_mbx_host_model.s_axi_wstrb <= 4'h0;
    wrOk(mbx_pkg::ADDR_INSTR, {18'h0, 14'h1000});
    i_mbx_host_model.s_axi_wstrb <= 4'he;
    wrOk(mbx_pkg::ADDR_ACC, {24'h0, ~accM});
    i_mbx_host_model.s_axi_wstrb <= 4'hf;
    rdChk(mbx_pkg::ADDR_PC, {19'h0, pcM});
    rdChk(mbx_pkg::ADDR_ACC, {24'h0, accM});
    $display("test strobes end");
    final_report();
  end
endmodule : tb
`default_nettype wire
